// *** pkg/tmh_pkg.sv ***
// constants shared by the tool manager handshake block
// assumes one 250 MHz clock and a plain register port of byte addresses
package tmh_pkg;

  // ==================================================
  // sizes
  localparam int NUM_MAG = 4;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STEP_W = 4;
  localparam int CH_STEP_W = 2;
  localparam int MAG_ACK_W = 10;
  localparam int CUT_W = 32;

  // ==================================================
  // magazine transfer step codes; ack vector bit is code minus one
  localparam logic [STEP_W-1:0] STEP_NONE = 4'h0;
  localparam logic [STEP_W-1:0] STEP_MZ_TO_ARM1 = 4'h1;
  localparam logic [STEP_W-1:0] STEP_ARM1_TO_SPDL = 4'h2;
  localparam logic [STEP_W-1:0] STEP_SPDL_TO_ARM1 = 4'h3;
  localparam logic [STEP_W-1:0] STEP_SPDL_TO_ARM2 = 4'h4;
  localparam logic [STEP_W-1:0] STEP_ARM1_TO_MZ = 4'h5;
  localparam logic [STEP_W-1:0] STEP_ARM2_TO_MZ = 4'h6;
  localparam logic [STEP_W-1:0] STEP_MZ_TO_SPDL = 4'h7;
  localparam logic [STEP_W-1:0] STEP_SPDL_TO_MZ = 4'h8;
  localparam logic [STEP_W-1:0] STEP_TURRET_ROT = 4'h9;
  localparam logic [STEP_W-1:0] STEP_CHANGE_END = 4'hA;

  // channel ground transfer step codes
  localparam logic [CH_STEP_W-1:0] CH_STEP_NONE = 2'h0;
  localparam logic [CH_STEP_W-1:0] CH_STEP_TO_GROUND = 2'h1;
  localparam logic [CH_STEP_W-1:0] CH_STEP_FROM_GROUND = 2'h2;

  // ==================================================
  // register map (byte addresses); groups use addr[3:2] as index
  localparam logic [ADDR_W-1:0] REG_MAG_STEP_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MAG_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CH_STEP_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] REG_CH_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] REG_LIFE_CTRL = 8'h34;
  localparam logic [ADDR_W-1:0] REG_CUT_COUNT_BASE = 8'h40;
  localparam int GROUP_LSB = 4;
  localparam int INDEX_LSB = 2;

  // status field positions
  localparam int MAG_EMERG_LSB = 0;
  localparam int MAG_DONE_LSB = 4;
  localparam int CH_REJECT_LSB = 0;
  localparam int CH_DONE_LSB = 4;
  localparam int CH_CUTTING_LSB = 8;

  // reset values and the cut count increment
  localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
  localparam logic [CUT_W-1:0] RST_CUT = 32'h0000_0000;
  localparam logic [CUT_W-1:0] CUT_ONE = 32'h0000_0001;

endpackage

// *** verilog/tmh_sync2.sv ***
// two flip-flop synchroniser for a bus of independent level inputs
// assumes every bit is a slow level; bits are not coherent with each other
`timescale 1ns/10ps
module tmh_sync2 #(
  parameter int W = 64
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // ==================================================
  // first stage feeds only the second stage
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// *** verilog/tmh_top.sv ***
// tool manager handshake block: emergency, cutting, reject and transfer
// acknowledges from the machine logic controller, four of each
// assumes controller inputs are asynchronous levels; register port is
// driven on clock_i with one-cycle strobes, read data one cycle later
//
// Functional notes
// - emergency-set high puts that magazine into tool manager emergency
// - emergency-clear high takes that magazine out of emergency
// - monitored tool counts machining time only while cutting bit is 1
// - reject bit high marks the channel's current tool for rejection
// - four instances of every magazine bit; first is the generic one
// - four instances of every channel bit
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module tmh_top
  import tmh_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [NUM_MAG-1:0] tool_mgr_emergency_set_i,
  input wire logic [NUM_MAG-1:0] tool_mgr_emergency_clear_i,
  input wire logic [NUM_MAG-1:0] ack_magazine_to_arm_one_i,
  input wire logic [NUM_MAG-1:0] ack_arm_one_to_spindle_i,
  input wire logic [NUM_MAG-1:0] ack_spindle_to_arm_one_i,
  input wire logic [NUM_MAG-1:0] ack_spindle_to_arm_two_i,
  input wire logic [NUM_MAG-1:0] ack_arm_one_to_magazine_i,
  input wire logic [NUM_MAG-1:0] ack_arm_two_to_magazine_i,
  input wire logic [NUM_MAG-1:0] ack_magazine_to_spindle_i,
  input wire logic [NUM_MAG-1:0] ack_spindle_to_magazine_i,
  input wire logic [NUM_MAG-1:0] turret_rotation_done_i,
  input wire logic [NUM_MAG-1:0] tool_change_complete_i,
  input wire logic [NUM_CH-1:0] tool_is_cutting_i,
  input wire logic [NUM_CH-1:0] tool_reject_request_i,
  input wire logic [NUM_CH-1:0] ack_spindle_to_ground_i,
  input wire logic [NUM_CH-1:0] ack_ground_to_spindle_i,
  output logic [NUM_MAG-1:0] tool_mgr_emergency_o,
  output logic [NUM_CH-1:0] tool_reject_o
);

  localparam int SYNC_W = NUM_MAG * 12 + NUM_CH * 4;

  // ==================================================
  // input synchronisation
  logic [SYNC_W-1:0] sync_q;
  logic [NUM_MAG-1:0] emg_set_s;
  logic [NUM_MAG-1:0] emg_clr_s;
  logic [NUM_MAG-1:0] mz2a1_s;
  logic [NUM_MAG-1:0] a1s_s;
  logic [NUM_MAG-1:0] s2a1_s;
  logic [NUM_MAG-1:0] s2a2_s;
  logic [NUM_MAG-1:0] a1mz_s;
  logic [NUM_MAG-1:0] a2mz_s;
  logic [NUM_MAG-1:0] mz2s_s;
  logic [NUM_MAG-1:0] s2mz_s;
  logic [NUM_MAG-1:0] rot_s;
  logic [NUM_MAG-1:0] chg_s;
  logic [NUM_CH-1:0] cut_s;
  logic [NUM_CH-1:0] rej_s;
  logic [NUM_CH-1:0] s2g_s;
  logic [NUM_CH-1:0] g2s_s;

  tmh_sync2 #(
    .W(SYNC_W)
  ) u_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i({tool_mgr_emergency_set_i, tool_mgr_emergency_clear_i,
          ack_magazine_to_arm_one_i, ack_arm_one_to_spindle_i,
          ack_spindle_to_arm_one_i, ack_spindle_to_arm_two_i,
          ack_arm_one_to_magazine_i, ack_arm_two_to_magazine_i,
          ack_magazine_to_spindle_i, ack_spindle_to_magazine_i,
          turret_rotation_done_i, tool_change_complete_i,
          tool_is_cutting_i, tool_reject_request_i,
          ack_spindle_to_ground_i, ack_ground_to_spindle_i}),
    .q_o(sync_q)
  );

  assign {emg_set_s, emg_clr_s, mz2a1_s, a1s_s, s2a1_s, s2a2_s, a1mz_s,
          a2mz_s, mz2s_s, s2mz_s, rot_s, chg_s, cut_s, rej_s, s2g_s,
          g2s_s} = sync_q;

  // ==================================================
  // register port decode
  logic [ADDR_W-1:0] addr_group;
  logic [1:0] addr_index;
  logic wr_mag_step;
  logic wr_mag_status;
  logic wr_ch_step;
  logic wr_ch_status;
  logic wr_life;
  logic wr_cut;

  assign addr_group = {reg_addr_i[ADDR_W-1:GROUP_LSB], {GROUP_LSB{1'b0}}};
  assign addr_index = reg_addr_i[INDEX_LSB+1:INDEX_LSB];
  assign wr_mag_step = reg_write_i && (addr_group == REG_MAG_STEP_BASE);
  assign wr_mag_status = reg_write_i && (reg_addr_i == REG_MAG_STATUS);
  assign wr_ch_step = reg_write_i && (addr_group == REG_CH_STEP_BASE);
  assign wr_ch_status = reg_write_i && (reg_addr_i == REG_CH_STATUS);
  assign wr_life = reg_write_i && (reg_addr_i == REG_LIFE_CTRL);
  assign wr_cut = reg_write_i && (addr_group == REG_CUT_COUNT_BASE);

  // ==================================================
  // per magazine state
  logic [STEP_W-1:0] mag_step [NUM_MAG];
  logic [MAG_ACK_W-1:0] mag_ack [NUM_MAG];
  logic [NUM_MAG-1:0] mag_hit;
  logic [NUM_MAG-1:0] mag_done;
  logic [NUM_MAG-1:0] emergency;

  genvar m;
  generate
    for (m = 0; m < NUM_MAG; m++) begin : g_mag
      logic [STEP_W-1:0] sel;
      logic step_wr;

      // index 0 doubles as the generic unsuffixed magazine
      assign mag_ack[m] = {chg_s[m], rot_s[m], s2mz_s[m], mz2s_s[m],
                           a2mz_s[m], a1mz_s[m], s2a2_s[m], s2a1_s[m],
                           a1s_s[m], mz2a1_s[m]};
      assign sel = mag_step[m] - STEP_MZ_TO_ARM1;
      // an ack with no matching step pending is ignored
      assign mag_hit[m] = (mag_step[m] != STEP_NONE) &&
                          mag_ack[m][sel];
      assign step_wr = wr_mag_step && (addr_index == 2'(m));

      // set wins over clear: a stuck set keeps the machine safe
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          emergency[m] <= 1'b0;
        end else if (emg_set_s[m]) begin
          emergency[m] <= 1'b1;
        end else if (emg_clr_s[m]) begin
          emergency[m] <= 1'b0;
        end
      end

      // a software write replaces any pending step; bad codes mean none
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          mag_step[m] <= STEP_NONE;
        end else if (step_wr) begin
          if (reg_wdata_i[STEP_W-1:0] > STEP_CHANGE_END) begin
            mag_step[m] <= STEP_NONE;
          end else begin
            mag_step[m] <= reg_wdata_i[STEP_W-1:0];
          end
        end else if (mag_hit[m]) begin
          mag_step[m] <= STEP_NONE;
        end
      end

      // sticky done; a new completion wins over write-one-to-clear
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          mag_done[m] <= 1'b0;
        end else if (mag_hit[m] && !step_wr) begin
          mag_done[m] <= 1'b1;
        end else if (wr_mag_status && reg_wdata_i[MAG_DONE_LSB + m]) begin
          mag_done[m] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==================================================
  // per channel state
  logic [CH_STEP_W-1:0] ch_step [NUM_CH];
  logic [CUT_W-1:0] cut_count [NUM_CH];
  logic [NUM_CH-1:0] ch_hit;
  logic [NUM_CH-1:0] ch_done;
  logic [NUM_CH-1:0] reject;
  logic [NUM_CH-1:0] life_en;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      life_en <= '0;
    end else if (wr_life) begin
      life_en <= reg_wdata_i[NUM_CH-1:0];
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic chs_wr;

      assign chs_wr = wr_ch_step && (addr_index == 2'(c));
      assign ch_hit[c] =
        ((ch_step[c] == CH_STEP_TO_GROUND) && s2g_s[c]) ||
        ((ch_step[c] == CH_STEP_FROM_GROUND) && g2s_s[c]);

      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ch_step[c] <= CH_STEP_NONE;
        end else if (chs_wr) begin
          if (reg_wdata_i[CH_STEP_W-1:0] > CH_STEP_FROM_GROUND) begin
            ch_step[c] <= CH_STEP_NONE;
          end else begin
            ch_step[c] <= reg_wdata_i[CH_STEP_W-1:0];
          end
        end else if (ch_hit[c]) begin
          ch_step[c] <= CH_STEP_NONE;
        end
      end

      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ch_done[c] <= 1'b0;
        end else if (ch_hit[c] && !chs_wr) begin
          ch_done[c] <= 1'b1;
        end else if (wr_ch_status && reg_wdata_i[CH_DONE_LSB + c]) begin
          ch_done[c] <= 1'b0;
        end
      end

      // reject stays flagged until software clears it; request wins
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          reject[c] <= 1'b0;
        end else if (rej_s[c]) begin
          reject[c] <= 1'b1;
        end else if (wr_ch_status && reg_wdata_i[CH_REJECT_LSB + c]) begin
          reject[c] <= 1'b0;
        end
      end

      // machining time in clock cycles; wraps silently at full scale
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          cut_count[c] <= RST_CUT;
        end else if (wr_cut && (addr_index == 2'(c))) begin
          cut_count[c] <= RST_CUT;
        end else if (life_en[c] && cut_s[c]) begin
          cut_count[c] <= cut_count[c] + CUT_ONE;
        end
      end
    end
  endgenerate

  // ==================================================
  // outputs
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tool_mgr_emergency_o <= '0;
      tool_reject_o <= '0;
    end else begin
      tool_mgr_emergency_o <= emergency;
      tool_reject_o <= reject;
    end
  end

  // ==================================================
  // read data, valid only the cycle after the read strobe
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = RST_DATA;
    if (addr_group == REG_MAG_STEP_BASE) begin
      rd_mux[STEP_W-1:0] = mag_step[addr_index];
    end else if (reg_addr_i == REG_MAG_STATUS) begin
      rd_mux[MAG_EMERG_LSB +: NUM_MAG] = emergency;
      rd_mux[MAG_DONE_LSB +: NUM_MAG] = mag_done;
    end else if (addr_group == REG_CH_STEP_BASE) begin
      rd_mux[CH_STEP_W-1:0] = ch_step[addr_index];
    end else if (reg_addr_i == REG_CH_STATUS) begin
      rd_mux[CH_REJECT_LSB +: NUM_CH] = reject;
      rd_mux[CH_DONE_LSB +: NUM_CH] = ch_done;
      rd_mux[CH_CUTTING_LSB +: NUM_CH] = cut_s;
    end else if (reg_addr_i == REG_LIFE_CTRL) begin
      rd_mux[NUM_CH-1:0] = life_en;
    end else if (addr_group == REG_CUT_COUNT_BASE) begin
      rd_mux = cut_count[addr_index];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= RST_DATA;
    end else if (reg_read_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= RST_DATA;
    end
  end

endmodule

// *** tb/tmh_top_sva.sv ***
// checker for the tool manager handshake outputs
// assumes it is bound into tmh_top and sees only its ports
`timescale 1ns/10ps
module tmh_top_chk
  import tmh_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic [NUM_MAG-1:0] tool_mgr_emergency_set_i,
  input wire logic [NUM_MAG-1:0] tool_mgr_emergency_clear_i,
  input wire logic [NUM_CH-1:0] tool_reject_request_i,
  input wire logic [NUM_MAG-1:0] tool_mgr_emergency_o,
  input wire logic [NUM_CH-1:0] tool_reject_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic [NUM_MAG-1:0] mag_cmd;
  logic wr_ch;
  assign mag_cmd = tool_mgr_emergency_set_i | tool_mgr_emergency_clear_i;
  assign wr_ch = reg_write_i && (reg_addr_i == REG_CH_STATUS);
  // ==================================================
  // emergency per magazine; inputs pass a two-flop synchroniser
  for (genvar m = 0; m < NUM_MAG; m++) begin : g_mag
    // synchroniser is still held on the release edge, so skip that start
    sequence s_set;
      (tool_mgr_emergency_set_i[m] && rst_b_i) [*4];
    endsequence
    sequence s_clr;
      (tool_mgr_emergency_clear_i[m] && !tool_mgr_emergency_set_i[m]) [*4];
    endsequence
    sequence s_quiet;
      !mag_cmd[m] [*5];
    endsequence
    AST_EMERG_SET: assert property (s_set |=> tool_mgr_emergency_o[m])
      else $error("emergency not raised by set");
    AST_EMERG_CLR: assert property (s_clr |=> !tool_mgr_emergency_o[m])
      else $error("emergency not dropped by clear");
    AST_EMERG_HOLD: assert property (s_quiet |=>
      $stable(tool_mgr_emergency_o[m]))
      else $error("emergency moved with no command");
    AST_EMERG_CAUSE: assert property (
      $changed(tool_mgr_emergency_o[m]) |->
      $past(mag_cmd[m], 2) || $past(mag_cmd[m], 3) || $past(mag_cmd[m], 4))
      else $error("emergency changed without own command");
  end
  // ==================================================
  // reject flag per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    sequence s_req;
      tool_reject_request_i[c] [*5];
    endsequence
    AST_REJECT_SET: assert property (s_req |=> tool_reject_o[c])
      else $error("reject flag not raised");
    AST_REJECT_CAUSE: assert property ($rose(tool_reject_o[c]) |->
      $past(tool_reject_request_i[c], 3) || $past(tool_reject_request_i[c], 4)
      || $past(tool_reject_request_i[c], 5))
      else $error("reject flag rose without own request");
    AST_REJECT_HOLD: assert property ($fell(tool_reject_o[c]) |->
      $past(wr_ch, 1) || $past(wr_ch, 2) || $past(wr_ch, 3))
      else $error("reject flag dropped without status write");
  end
endmodule

bind tmh_top tmh_top_chk i_chk (.clock_i, .rst_b_i, .reg_addr_i,
  .reg_write_i, .tool_mgr_emergency_set_i, .tool_mgr_emergency_clear_i,
  .tool_reject_request_i, .tool_mgr_emergency_o, .tool_reject_o);

// *** tb/tmh_plc_model.sv ***
// model of the machine logic controller driving the handshake marks
// assumes the bench calls move and sets the mode levels hierarchically
`timescale 1ns/10ps
module tmh_plc_model
  import tmh_pkg::*;
(
  input wire logic clock_i,
  output logic [11:0][NUM_MAG-1:0] ack_o,
  output logic [NUM_CH-1:0] cut_o
);
  logic [NUM_CH-1:0] automatic_mode_active;
  logic [NUM_CH-1:0] block_executing;
  logic [NUM_CH-1:0] rapid_active;
  initial begin
    ack_o = '0;
    automatic_mode_active = '0;
    block_executing = '0;
    rapid_active = '0;
  end
  assign cut_o = automatic_mode_active & block_executing &
                 ~rapid_active;
  // ack index is step code minus one; 10 and 11 are the ground moves
  task automatic move(input int idx, input int m, input int dly);
    repeat (dly) @(posedge clock_i);
    ack_o[idx][m] <= 1'b1;
    // held long enough to cross the synchroniser, then dropped for reuse
    repeat (6) @(posedge clock_i);
    ack_o[idx][m] <= 1'b0;
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the tool manager handshake block
// assumes tmh_top, the controller model and the bound checker
`timescale 1ns/10ps
module tb_top
  import tmh_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [NUM_MAG-1:0] em_set = '0;
  logic [NUM_MAG-1:0] em_clr = '0;
  logic [NUM_CH-1:0] rej = '0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_MAG-1:0] emerg;
  logic [NUM_CH-1:0] rej_out;
  logic [11:0][NUM_MAG-1:0] ack;
  logic [NUM_CH-1:0] cut;
  int failures = 0;
  int checks_done = 0;
  always #2 clock_i = ~clock_i;
  tmh_plc_model i_plc (.clock_i(clock_i), .ack_o(ack), .cut_o(cut));
  tmh_top i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
    .reg_rdata_o(rdata), .tool_mgr_emergency_set_i(em_set),
    .tool_mgr_emergency_clear_i(em_clr), .ack_magazine_to_arm_one_i(ack[0]),
    .ack_arm_one_to_spindle_i(ack[1]), .ack_spindle_to_arm_one_i(ack[2]),
    .ack_spindle_to_arm_two_i(ack[3]), .ack_arm_one_to_magazine_i(ack[4]),
    .ack_arm_two_to_magazine_i(ack[5]), .ack_magazine_to_spindle_i(ack[6]),
    .ack_spindle_to_magazine_i(ack[7]), .turret_rotation_done_i(ack[8]),
    .tool_change_complete_i(ack[9]), .tool_is_cutting_i(cut),
    .tool_reject_request_i(rej), .ack_spindle_to_ground_i(ack[10]),
    .ack_ground_to_spindle_i(ack[11]), .tool_mgr_emergency_o(emerg),
    .tool_reject_o(rej_out));
  // ==================================================
  // register port and comparisons
  task automatic wr_reg(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] v);
    @(posedge clock_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [DATA_W-1:0] g,
    input logic [DATA_W-1:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_out(input logic [3:0] g, input logic [3:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // read data stand only in the cycle after the strobe, sampled mid-cycle;
  // returns on a rising edge so callers drive inputs there
  task automatic rd_chk(input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(negedge clock_i);
    chk_reg(rdata, e);
    @(posedge clock_i);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==================================================
  // tests
  initial begin
    int m;
    logic [ADDR_W-1:0] sa;
    logic [ADDR_W-1:0] ta;
    logic [DATA_W-1:0] code;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    chk_out(emerg, 4'h0);
    rd_chk(REG_MAG_STATUS, RST_DATA);
    wr_reg(8'hFC, 32'hFFFF_FFFF);
    rd_chk(8'hFC, RST_DATA);
    $display("test reset done");
    for (int i = 0; i < NUM_MAG; i++) begin
      em_set[i] <= 1'b1;
      repeat (6) @(posedge clock_i);
      chk_out(emerg, (4'h1 << (i + 1)) - 4'h1);
    end
    em_clr <= 4'h4;
    wr_reg(REG_MAG_STATUS, 32'h0000_000F);
    rd_chk(REG_MAG_STATUS, 32'h0000_000F);
    em_set <= 4'hB;
    repeat (6) @(posedge clock_i);
    chk_out(emerg, 4'hB);
    em_set <= 4'h0;
    em_clr <= 4'hF;
    repeat (6) @(posedge clock_i);
    chk_out(emerg, 4'h0);
    em_clr <= 4'h0;
    $display("test emergency done");
    for (int i = 0; i < 12; i++) begin
      m = i % 4;
      sa = (i < 10) ? REG_MAG_STEP_BASE : REG_CH_STEP_BASE;
      sa = sa + ADDR_W'(4 * m);
      ta = (i < 10) ? REG_MAG_STATUS : REG_CH_STATUS;
      code = (i < 10) ? DATA_W'(i + 1) : DATA_W'(i - 9);
      wr_reg(sa, code);
      i_plc.move((i + 1) % 12, m, 0);
      rd_chk(sa, code);
      i_plc.move(i, m, (i % 2) * 20);
      rd_chk(sa, RST_DATA);
      rd_chk(ta, DATA_W'(1 << (4 + m)));
      wr_reg(ta, DATA_W'(1 << (4 + m)));
      rd_chk(ta, RST_DATA);
    end
    $display("test transfers done");
    for (int c = 0; c < NUM_CH; c++) begin
      rej[c] <= 1'b1;
      repeat (8) @(posedge clock_i);
      chk_out(rej_out, 4'h1 << c);
      rej[c] <= 1'b0;
      repeat (4) @(posedge clock_i);
      rd_chk(REG_CH_STATUS, DATA_W'(1 << c));
      wr_reg(REG_CH_STATUS, DATA_W'(1 << c));
      repeat (3) @(posedge clock_i);
      chk_out(rej_out, 4'h0);
    end
    $display("test reject done");
    wr_reg(REG_LIFE_CTRL, 32'h0000_0001);
    i_plc.rapid_active <= 4'hF;
    i_plc.automatic_mode_active <= 4'h3;
    i_plc.block_executing <= 4'h3;
    repeat (20) @(posedge clock_i);
    i_plc.rapid_active <= 4'h0;
    repeat (10) @(posedge clock_i);
    rd_chk(REG_CH_STATUS, 32'h0000_0300);
    repeat (7) @(posedge clock_i);
    i_plc.block_executing <= 4'h0;
    repeat (6) @(posedge clock_i);
    rd_chk(REG_CUT_COUNT_BASE, 32'h0000_0014);
    rd_chk(REG_CUT_COUNT_BASE + 8'h04, RST_DATA);
    $display("test cutting done");
    em_set <= 4'h1;
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk_out(emerg, 4'h0);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk_out(emerg, 4'h1);
    $display("test second reset done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    stop_test();
  end
endmodule
